// ===== hw/srf_params.svh
// Constants for the supply rejection feedback register bank
`ifndef SRF_PARAMS_SVH
`define SRF_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SRF_OFS_CONFIG     8'h34
`define SRF_OFS_COEFF_HIGH 8'h35
`define SRF_OFS_COEFF_MID  8'h36
`define SRF_OFS_COEFF_LOW  8'h37
`define SRF_OFS_READ_HIGH  8'h3B
`define SRF_OFS_READ_MID   8'h3C
`define SRF_OFS_READ_LOW   8'h3D

// ****************************************************************
// Configuration byte fields
// ****************************************************************
`define SRF_CFG_ENABLE_BIT 7
`define SRF_CFG_RESET_BIT  6
`define SRF_CFG_FBEN_BIT   5
`define SRF_CFG_DIV_MSB    2
`define SRF_CFG_DIV_LSB    0
`define SRF_CFG_WMASK      8'hE7

// ****************************************************************
// Coefficient high byte fields
// ****************************************************************
`define SRF_EXP_MSB        6
`define SRF_EXP_LSB        4
`define SRF_MANT_HI_MSB    2
`define SRF_MANT_HI_LSB    0

// ****************************************************************
// Reset values
// ****************************************************************
`define SRF_CONFIG_RST     8'h00
`define SRF_EXP_RST        3'h2
`define SRF_MANT_RST       19'h2_5868
`define SRF_READING_RST    24'h00_0000
`define SRF_BYTE_ZERO      8'h00

// ****************************************************************
// Arithmetic and divider
// ****************************************************************
`define SRF_MANT_FRAC      18
`define SRF_DIV_OFF        3'h0
`define SRF_DIV_MAXCODE    3'h6
`define SRF_DIV_BASE_HALF  10'h010
`define SRF_DIV_CODE32     3'h1
`define SRF_RUN_MAX        5'h1F
`define SRF_DIV32_RUN      5'h11

`endif

// ===== hw/srf_pkg.sv
// Types shared by the supply rejection feedback blocks
package srf_pkg;
  typedef logic [23:0] srf_reading_t;
  typedef logic [18:0] srf_mant_t;
  typedef logic [2:0]  srf_exp_t;
  typedef logic [2:0]  srf_div_t;
  typedef logic [7:0]  srf_byte_t;
endpackage : srf_pkg

// ===== hw/srf_sync_div.sv
// Crystal clock divider for the supply sync clock
`timescale 1ns/1ns
`include "srf_params.svh"

module srf_sync_div (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Divider code
  input  wire srf_pkg::srf_div_t div_code,
  // Divided outputs
  output logic                  sync_clock,
  output logic                  sync_tick
);

  logic [9:0]        cnt_reg;
  logic [9:0]        cnt_next;
  logic              clk_reg;
  logic              clk_next;
  logic              tick_reg;
  logic              tick_next;
  srf_pkg::srf_div_t code_reg;
  logic [9:0]        half_period;

  // Half period 16 << (code-1): divide by 32 .. 1024
  function automatic logic [9:0] half_of(input srf_pkg::srf_div_t code);
    half_of = `SRF_DIV_BASE_HALF << (code - 3'h1);
  endfunction : half_of

  assign half_period = half_of(div_code);

  always_comb begin
    cnt_next  = cnt_reg;
    clk_next  = clk_reg;
    tick_next = 1'b0;
    if (div_code == `SRF_DIV_OFF || div_code > `SRF_DIV_MAXCODE ||
        div_code != code_reg) begin
      cnt_next = '0;
      clk_next = 1'b0;
    end else if (cnt_reg == half_period - 10'h001) begin
      cnt_next  = '0;
      clk_next  = ~clk_reg;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 10'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg  <= '0;
      clk_reg  <= 1'b0;
      tick_reg <= 1'b0;
      code_reg <= `SRF_DIV_OFF;
    end else begin
      cnt_reg  <= cnt_next;
      clk_reg  <= clk_next;
      tick_reg <= tick_next;
      code_reg <= div_code;
    end
  end

  assign sync_clock = clk_reg;
  assign sync_tick  = tick_reg;

endmodule : srf_sync_div

// ===== hw/srf_scaler.sv
// Coefficient scaler for the measured supply value
`timescale 1ns/1ns
`include "srf_params.svh"

module srf_scaler (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 srst,
  // Raw measurement and coefficient
  input  wire logic                 in_valid,
  input  wire srf_pkg::srf_reading_t in_data,
  input  wire srf_pkg::srf_mant_t   mant,
  input  wire srf_pkg::srf_exp_t    expo,
  // Scaled result, signed 2.22
  output logic                      out_valid,
  output srf_pkg::srf_reading_t     out_data
);

  logic signed [42:0]    prod;
  logic signed [50:0]    shifted;
  logic                  valid_reg;
  logic                  valid_next;
  srf_pkg::srf_reading_t data_reg;
  srf_pkg::srf_reading_t data_next;

  // Clamp to the signed 24-bit range
  function automatic srf_pkg::srf_reading_t sat24(input logic signed [32:0] v);
    if (v > 33'sh0_007F_FFFF)
      sat24 = 24'h7F_FFFF;
    else if (v < -33'sh0_0080_0000)
      sat24 = 24'h80_0000;
    else
      sat24 = v[23:0];
  endfunction : sat24

  // 2.22 times 1.18 gives 40 fraction bits; drop 18 to stay 2.22
  assign prod    = $signed(in_data) * $signed(mant);
  assign shifted = $signed({{8{prod[42]}}, prod}) <<< expo;

  always_comb begin
    valid_next = in_valid;
    data_next  = data_reg;
    if (in_valid) begin
      data_next = sat24(shifted[50:`SRF_MANT_FRAC]);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      valid_reg <= 1'b0;
      data_reg  <= `SRF_READING_RST;
    end else begin
      valid_reg <= valid_next;
      data_reg  <= data_next;
    end
  end

  assign out_valid = valid_reg;
  assign out_data  = data_reg;

endmodule : srf_scaler

// ===== hw/srf_regs.sv
// Supply rejection feedback register bank, top level
// Overview of operation
// - Enable bit drives the enable pin level and turns on internal rejection; default 0.
// - Reset bit at 0, the default, holds the external reset pin low.
// - Feedback enable bit gates internal feedback logic; default off.
// - Divider code: 000 off, 001..110 divide crystal clock by 32..1024.
// - Coefficient is mantissa times two to the exponent; exponent default 010.
// - Mantissa is 19-bit signed 1.18, default 25868h.
// - Supply reading is 24-bit signed 2.22.
// - Reading register is read-only, resets to zero, tracks measured supply.
// - Calibrated quiet DC supply reads 1.0, that is 400000h.
// - Configuration byte at 34h: enable, reset, feedback, reserved, divider.
`timescale 1ns/1ns
`include "srf_params.svh"

module srf_regs (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  srst,
  // Control port byte access
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [7:0]                 reg_rdata,
  output logic                       reg_rd_valid,
  // Measurement from the external feedback circuit
  input  wire logic                  meas_valid,
  input  wire srf_pkg::srf_reading_t meas_data,
  // Pins to the external rejection circuitry
  output logic                       supply_reject_enable,
  output logic                       supply_reject_reset_n,
  output logic                       supply_sync_clock,
  // Internal feedback path
  output logic                       feedback_active,
  output logic                       feedback_valid,
  output srf_pkg::srf_reading_t      feedback_value
);

  // ****************************************************************
  // State
  // ****************************************************************
  srf_pkg::srf_byte_t    cfg_reg;
  srf_pkg::srf_byte_t    cfg_next;
  srf_pkg::srf_exp_t     exp_reg;
  srf_pkg::srf_exp_t     exp_next;
  srf_pkg::srf_mant_t    mant_reg;
  srf_pkg::srf_mant_t    mant_next;
  srf_pkg::srf_reading_t reading_reg;
  srf_pkg::srf_reading_t reading_next;
  srf_pkg::srf_byte_t    rdata_reg;
  srf_pkg::srf_byte_t    rdata_next;
  logic                  rvalid_reg;
  logic                  rvalid_next;
  logic                  active_reg;
  logic                  active_next;
  logic                  fb_valid_reg;
  logic                  fb_valid_next;
  srf_pkg::srf_reading_t fb_value_reg;
  srf_pkg::srf_reading_t fb_value_next;

  logic                  sc_valid;
  srf_pkg::srf_reading_t sc_data;
  srf_pkg::srf_div_t     div_code;
  logic                  rej_en;
  logic                  fb_en;

  // Write strobe for one register offset
  function automatic logic wr_hit(input logic wr, input logic [7:0] addr,
                                  input logic [7:0] ofs);
    wr_hit = wr && (addr == ofs);
  endfunction : wr_hit

  assign rej_en   = cfg_reg[`SRF_CFG_ENABLE_BIT];
  assign fb_en    = cfg_reg[`SRF_CFG_FBEN_BIT];
  assign div_code = cfg_reg[`SRF_CFG_DIV_MSB:`SRF_CFG_DIV_LSB];

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_comb begin
    cfg_next  = cfg_reg;
    exp_next  = exp_reg;
    mant_next = mant_reg;
    if (wr_hit(reg_wr, reg_addr, `SRF_OFS_CONFIG)) begin
      cfg_next = reg_wdata & `SRF_CFG_WMASK;
    end
    if (wr_hit(reg_wr, reg_addr, `SRF_OFS_COEFF_HIGH)) begin
      exp_next         = reg_wdata[`SRF_EXP_MSB:`SRF_EXP_LSB];
      mant_next[18:16] = reg_wdata[`SRF_MANT_HI_MSB:`SRF_MANT_HI_LSB];
    end
    if (wr_hit(reg_wr, reg_addr, `SRF_OFS_COEFF_MID)) begin
      mant_next[15:8] = reg_wdata;
    end
    if (wr_hit(reg_wr, reg_addr, `SRF_OFS_COEFF_LOW)) begin
      mant_next[7:0] = reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_reg  <= `SRF_CONFIG_RST;
      exp_reg  <= `SRF_EXP_RST;
      mant_reg <= `SRF_MANT_RST;
    end else begin
      cfg_reg  <= cfg_next;
      exp_reg  <= exp_next;
      mant_reg <= mant_next;
    end
  end

  // ****************************************************************
  // Measured supply value
  // ****************************************************************
  srf_scaler u_scaler (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (meas_valid),
    .in_data   (meas_data),
    .mant      (mant_reg),
    .expo      (exp_reg),
    .out_valid (sc_valid),
    .out_data  (sc_data)
  );

  // Writes to the reading offsets are ignored
  always_comb begin
    reading_next = reading_reg;
    if (sc_valid) begin
      reading_next = sc_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reading_reg <= `SRF_READING_RST;
    end else begin
      reading_reg <= reading_next;
    end
  end

  // ****************************************************************
  // Feedback gating and pins
  // ****************************************************************
  always_comb begin
    active_next   = rej_en && fb_en;
    fb_valid_next = 1'b0;
    fb_value_next = fb_value_reg;
    if (!active_next) begin
      fb_value_next = `SRF_READING_RST;
    end else if (sc_valid) begin
      fb_valid_next = 1'b1;
      fb_value_next = sc_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      active_reg   <= 1'b0;
      fb_valid_reg <= 1'b0;
      fb_value_reg <= `SRF_READING_RST;
    end else begin
      active_reg   <= active_next;
      fb_valid_reg <= fb_valid_next;
      fb_value_reg <= fb_value_next;
    end
  end

  // Pin levels follow the configuration flops directly
  assign supply_reject_enable  = cfg_reg[`SRF_CFG_ENABLE_BIT];
  assign supply_reject_reset_n = cfg_reg[`SRF_CFG_RESET_BIT];
  assign feedback_active       = active_reg;
  assign feedback_valid        = fb_valid_reg;
  assign feedback_value        = fb_value_reg;

  srf_sync_div u_sync_div (
    .clk        (clk),
    .srst       (srst),
    .div_code   (div_code),
    .sync_clock (supply_sync_clock),
    .sync_tick  ()
  );

  // ****************************************************************
  // Register reads
  // ****************************************************************
  always_comb begin
    rvalid_next = reg_rd;
    rdata_next  = rdata_reg;
    if (reg_rd) begin
      case (reg_addr)
        `SRF_OFS_CONFIG:     rdata_next = cfg_reg;
        `SRF_OFS_COEFF_HIGH: rdata_next = {1'b0, exp_reg, 1'b0, mant_reg[18:16]};
        `SRF_OFS_COEFF_MID:  rdata_next = mant_reg[15:8];
        `SRF_OFS_COEFF_LOW:  rdata_next = mant_reg[7:0];
        `SRF_OFS_READ_HIGH:  rdata_next = reading_reg[23:16];
        `SRF_OFS_READ_MID:   rdata_next = reading_reg[15:8];
        `SRF_OFS_READ_LOW:   rdata_next = reading_reg[7:0];
        default:             rdata_next = `SRF_BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_reg  <= `SRF_BYTE_ZERO;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign reg_rdata    = rdata_reg;
  assign reg_rd_valid = rvalid_reg;

  // ****************************************************************
  // Assertion helpers
  // ****************************************************************
  // Cycles the divide-by-32 code has stood, saturating
  logic [4:0]            div32_run_reg;
  logic [4:0]            div32_run_next;

  always_comb begin
    div32_run_next = '0;
    if (div_code == `SRF_DIV_CODE32) begin
      div32_run_next = div32_run_reg;
      if (div32_run_reg != `SRF_RUN_MAX) begin
        div32_run_next = div32_run_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      div32_run_reg <= '0;
    end else begin
      div32_run_reg <= div32_run_next;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence cfg_write_s;
    reg_wr && reg_addr == `SRF_OFS_CONFIG;
  endsequence

  sequence rd_of_s(logic [7:0] ofs);
    reg_rd && reg_addr == ofs;
  endsequence

  enable_pin_a: assert property (cfg_write_s |=>
      supply_reject_enable == $past(reg_wdata[7]))
    else $error("enable pin does not follow written bit");

  reset_pin_a: assert property (cfg_write_s ##0 !reg_wdata[6] ##1 !reg_wr
      |-> !supply_reject_reset_n)
    else $error("external reset not held low");

  feedback_gate_a: assert property (!fb_en |=> !feedback_valid
      && feedback_value == 24'h00_0000)
    else $error("feedback passes while disabled");

  sync_off_a: assert property ((div_code == 3'h0)[*2] |-> !supply_sync_clock)
    else $error("sync clock runs while disabled");

  sequence sync_rise_s;
    $rose(supply_sync_clock);
  endsequence

  // Code held from the cycle before the rise to the one before the fall
  sequence div32_held_s;
    div32_run_reg >= `SRF_DIV32_RUN;
  endsequence

  sync_period_a: assert property (sync_rise_s ##16 div32_held_s
      |-> $fell(supply_sync_clock))
    else $error("divide by 32 period wrong");

  fb_pulse_a: assert property (sc_valid && rej_en && fb_en |=> feedback_valid
      && feedback_value == $past(sc_data))
    else $error("feedback result not passed while enabled");

  reading_ro_a: assert property (reg_wr && reg_addr == `SRF_OFS_READ_HIGH
      && !sc_valid |=> $stable(reading_reg))
    else $error("reading register changed by a write");

  reading_track_a: assert property (sc_valid |=> reading_reg == $past(sc_data))
    else $error("reading does not track measurement");

  reserved_rd_a: assert property (rd_of_s(`SRF_OFS_CONFIG) |=>
      reg_rd_valid && reg_rdata[4:3] == 2'h0)
    else $error("reserved config bits read nonzero");

  exp_high_a: assert property (rd_of_s(`SRF_OFS_COEFF_HIGH) |=>
      reg_rdata[6:4] == $past(exp_reg) && reg_rdata[2:0] == $past(mant_reg[18:16]))
    else $error("coefficient high byte misplaced");

  read_high_a: assert property (rd_of_s(`SRF_OFS_READ_HIGH) |=>
      reg_rdata == $past(reading_reg[23:16]))
    else $error("reading high byte misplaced");

  unity_scale_a: assert property (meas_valid && meas_data == 24'h40_0000
      && mant_reg == 19'h2_0000 && exp_reg == 3'h1 |=> sc_data == 24'h40_0000)
    else $error("unity coefficient changes reading");

  reset_vals_a: assert property ($past(srst) && !srst |-> cfg_reg == 8'h00
      && exp_reg == 3'h2 && mant_reg == 19'h2_5868 && reading_reg == 24'h00_0000)
    else $error("reset values wrong");

endmodule : srf_regs

// ===== test/srf_supply_model.sv
// Behavioural model of the external supply rejection feedback circuit
`timescale 1ns/1ns

module srf_supply_model (
  // Clock
  input  wire logic        clk,
  // Pins from the register bank
  input  wire logic        supply_reject_enable,
  input  wire logic        supply_reject_reset_n,
  // Measurement request from the bench
  input  wire logic        req,
  input  wire logic [23:0] req_data,
  // Measurement to the register bank
  output logic             meas_valid,
  output logic [23:0]      meas_data
);
  initial begin
    meas_valid = 1'h0;
    meas_data  = 24'h00_0000;
  end

  // Parts held in reset or disabled never measure
  // Data line shows the inverse of the last value outside a strobe
  always @(posedge clk) begin
    meas_valid <= req & supply_reject_reset_n & supply_reject_enable;
    meas_data  <= req ? req_data : ~meas_data;
  end
endmodule : srf_supply_model

// ===== test/tb.sv
// Self-checking bench for the supply rejection feedback register bank
`timescale 1ns/1ns

module tb;
  typedef struct {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] e;} srf_row_t;
  typedef struct {logic [23:0] m; logic [18:0] c; logic [2:0] x;} srf_meas_t;

  logic        clk, srst, reg_wr, reg_rd, reg_rd_valid, meas_valid, req;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd;
  logic [23:0] meas_data, req_data, feedback_value;
  logic        supply_reject_enable, supply_reject_reset_n, supply_sync_clock;
  logic        feedback_active, feedback_valid;
  logic [18:0] mant_cur;
  logic [2:0]  exp_cur;
  int          miscompares, comparisons, cycles, n, hi;

  srf_row_t rows [13] = '{
    '{0, 8'h34, 8'h00, 8'h00}, '{0, 8'h35, 8'h00, 8'h22}, '{0, 8'h36, 8'h00, 8'h58},
    '{0, 8'h37, 8'h00, 8'h68}, '{0, 8'h3B, 8'h00, 8'h00}, '{0, 8'h3C, 8'h00, 8'h00},
    '{0, 8'h3D, 8'h00, 8'h00}, '{1, 8'h34, 8'hFF, 8'hE7}, '{1, 8'h35, 8'hFF, 8'h77},
    '{1, 8'h36, 8'hA5, 8'hA5}, '{1, 8'h37, 8'h5A, 8'h5A}, '{1, 8'h3B, 8'hFF, 8'h00},
    '{1, 8'h50, 8'hFF, 8'h00}};
  srf_meas_t meas [5] = '{
    '{24'h40_0000, 19'h2_0000, 3'h1}, '{24'h40_0000, 19'h2_8851, 3'h2},
    '{24'h7F_FFFF, 19'h3_FFFF, 3'h7}, '{24'h80_0000, 19'h3_FFFF, 3'h7},
    '{24'h20_0000, 19'h4_0000, 3'h0}};

  srf_regs uut (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .meas_valid(meas_valid), .meas_data(meas_data),
    .supply_reject_enable(supply_reject_enable), .supply_reject_reset_n(supply_reject_reset_n),
    .supply_sync_clock(supply_sync_clock), .feedback_active(feedback_active),
    .feedback_valid(feedback_valid), .feedback_value(feedback_value));

  srf_supply_model model (
    .clk(clk), .supply_reject_enable(supply_reject_enable),
    .supply_reject_reset_n(supply_reject_reset_n), .req(req), .req_data(req_data),
    .meas_valid(meas_valid), .meas_data(meas_data));

  // ****************************************************************
  // Clock, timeout and helpers
  // ****************************************************************
  always #5 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check

  task automatic tally_and_finish();
    if (miscompares == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'h1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'h0;
    @(negedge clk);
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    reg_rd = 1'h1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'h0;
    check(reg_rd_valid, 1'h1);
    d = reg_rdata;
    @(negedge clk);
  endtask : reg_read

  task automatic set_coeff(input logic [18:0] c, input logic [2:0] x);
    reg_write(8'h35, {1'h0, x, 1'h0, c[18:16]});
    reg_write(8'h36, c[15:8]);
    reg_write(8'h37, c[7:0]);
    mant_cur = c;
    exp_cur = x;
  endtask : set_coeff

  function automatic logic [23:0] scale(input logic [23:0] m, input logic [18:0] c,
                                        input logic [2:0] x);
    longint p;
    p = longint'(signed'(m)) * longint'(signed'(c));
    p = (p <<< x) >>> 18;
    if (p > 64'sh7F_FFFF) p = 64'sh7F_FFFF;
    if (p < -64'sh80_0000) p = -64'sh80_0000;
    return p[23:0];
  endfunction : scale

  task automatic measure(input logic [23:0] m, input logic act);
    logic [23:0] e;
    e = scale(m, mant_cur, exp_cur);
    req = 1'h1;
    req_data = m;
    @(negedge clk);
    req = 1'h0;
    check(meas_valid, 1'h1);
    @(negedge clk);
    check(feedback_valid, 1'h0);
    @(negedge clk);
    check(feedback_valid, act);
    check(feedback_value, act ? e : 24'h00_0000);
    reg_read(8'h3B, rd);
    check(rd, e[23:16]);
    reg_read(8'h3C, rd);
    check(rd, e[15:8]);
    reg_read(8'h3D, rd);
    check(rd, e[7:0]);
  endtask : measure

  task automatic wait_rise(output int k);
    logic p;
    k = 0;
    p = supply_sync_clock;
    @(negedge clk);
    k = 1;
    while (!(p === 1'h0 && supply_sync_clock === 1'h1) && k < 3000) begin
      p = supply_sync_clock;
      @(negedge clk);
      k++;
    end
  endtask : wait_rise

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    clk = 1'h0; srst = 1'h1; reg_wr = 1'h0; reg_rd = 1'h0; reg_addr = 8'h00;
    reg_wdata = 8'h00; req = 1'h0; req_data = 24'h00_0000;
    miscompares = 0; comparisons = 0; cycles = 0;
    repeat (3) @(negedge clk);
    srst = 1'h0;
    check({supply_reject_enable, supply_reject_reset_n}, 2'h0);
    check(supply_sync_clock, 1'h0);
    mant_cur = 19'h2_5868;
    exp_cur = 3'h2;
    foreach (rows[i]) begin
      if (rows[i].wr) reg_write(rows[i].a, rows[i].d);
      reg_read(rows[i].a, rd);
      check(rd, rows[i].e);
    end
    // Released from reset, feedback gated off
    reg_write(8'h34, 8'hC0);
    check({supply_reject_enable, supply_reject_reset_n}, 2'h3);
    check(feedback_active, 1'h0);
    set_coeff(19'h2_0000, 3'h1);
    measure(24'h40_0000, 1'h0);
    reg_write(8'h34, 8'hE0);
    check(feedback_active, 1'h1);
    foreach (meas[i]) begin
      set_coeff(meas[i].c, meas[i].x);
      measure(meas[i].m, 1'h1);
    end
    // Divider periods for every active code
    for (int code = 1; code <= 6; code++) begin
      reg_write(8'h34, 8'hC0 | code[7:0]);
      wait_rise(n);
      wait_rise(n);
      check(n, 32 << (code - 1));
    end
    // Reset in mid-run restores every default
    srst = 1'h1;
    repeat (3) @(negedge clk);
    srst = 1'h0;
    check({supply_reject_enable, supply_reject_reset_n}, 2'h0);
    check({supply_sync_clock, feedback_active, feedback_valid}, 3'h0);
    reg_read(8'h35, rd);
    check(rd, 8'h22);
    reg_read(8'h37, rd);
    check(rd, 8'h68);
    reg_read(8'h3B, rd);
    check(rd, 8'h00);
    // Disabled codes keep the sync clock low
    for (int j = 0; j < 2; j++) begin
      reg_write(8'h34, j == 0 ? 8'h07 : 8'h00);
      hi = 0;
      repeat (80) begin
        @(negedge clk);
        if (supply_sync_clock !== 1'h0) hi++;
      end
      check(hi, 0);
    end
    check({supply_reject_enable, supply_reject_reset_n}, 2'h0);
    tally_and_finish();
  end
endmodule : tb
